// ===== hdl/scps_map.svh
// Register offsets, field positions, reset values and identifiers for the sideband state block.
// Included by the package-aware design file; holds definitions only.
`ifndef SCPS_MAP_SVH
`define SCPS_MAP_SVH
`define SCPS_OFF_CTRL    12'h000
`define SCPS_OFF_CMD     12'h004
`define SCPS_OFF_RESP    12'h008
`define SCPS_OFF_STAT    12'h00C
`define SCPS_OFF_IRQ_ST  12'h010
`define SCPS_OFF_IRQ_MSK 12'h014
`define SCPS_OFF_TXREQ   12'h018
`define SCPS_CTRL_SEL     0
`define SCPS_CTRL_ARB_EN  1
`define SCPS_CTRL_PKG_RDY 2
`define SCPS_CTRL_CH_RDY  3
`define SCPS_CTRL_CH_INIT 4
`define SCPS_CTRL_RST     32'h0000_0006
`define SCPS_PKG_ID_DEF   3'h0
`define SCPS_INT_CH_DEF   5'h00
`define SCPS_PKG_CH_ID    5'h1F
`define SCPS_CODE_OK      8'h00
`define SCPS_CODE_FAIL    8'h01
`define SCPS_CODE_UNAV    8'h02
`define SCPS_REASON_NONE  8'h00
`define SCPS_REASON_INIT  8'h01
`define SCPS_TYPE_CLR_INIT 7'h00
`define SCPS_TYPE_ENABLE   7'h04
`define SCPS_TYPE_DISABLE  7'h05
`define SCPS_TYPE_VENDOR   7'h50
`endif

// ===== hdl/scps_pkg.sv
// Types shared by the sideband state block.
// Assumes the map header supplies all numeric constants.
package scps_pkg;
  typedef enum logic [1:0] {SCPS_IDLE, SCPS_HOLD, SCPS_SEND} scps_resp_state_t;
  typedef logic [7:0] scps_byte_t;
endpackage

// ===== hdl/scps_core.sv
// Package and channel operational state with transmit gating and command answering.
// Assumes an APB master on MCLK and pin-level arbitration grant from outside.
// What this block does
// - Response carries command's instance tag unchanged
// - Exactly one response per accepted command
// - Only commands and responses are tag-tracked
// - Multi-byte fields sent MSB and msbit first
// - Selected package may drive and transmit
// - Deselected package keeps buffers off, silent
// - Arbitration on needs select plus grant
// - Arbitration off: selected is enough
// - Package-ready accepts package commands, may select
// - Package-not-ready refuses package commands
// - Channel-ready accepts commands matching its identifier
// - Channel-not-ready refuses channel commands
// - Initial state answers, flags configuration needed
// - Enabled channel sends unrequested packets when selected
// - Disabled channel sends no unrequested packets
// - Initial state fails commands other than vendor and clear-initial, init reason
// - Only clear-initial command leaves initial state
// - Entering initial state disables the channel
`timescale 1ns/1ps
`include "scps_map.svh"
module scps_core
  import scps_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        ARB_GRANT,
  input  wire logic        INIT_EVENT,
  output logic             TX_BUF_EN,
  output logic             TX_RESP_OK,
  output logic             TX_UNREQ_OK,
  output logic             IRQ
);
  // Register layout: CMD = {instance_tag[31:24], type[22:16], pkg[7:5], ch[4:0]}.
  // RESP = {valid[31], instance_tag[23:16], code[15:8], reason[7:0]}; reading pops it.
  // STAT = {init[4], ch_enabled[3], tx_allowed[2], ch_rdy[1], pkg_rdy[0]}.
  // IRQ bits: 0 response ready, 1 initial state entered, 2 command refused.
  logic [31:0]      ctrl_q;
  logic             ch_en_q;
  logic             init_q;
  logic             resp_v_q;
  scps_byte_t       resp_tag_q;
  scps_byte_t       resp_code_q;
  scps_byte_t       resp_rsn_q;
  logic [2:0]       irq_st_q;
  logic [2:0]       irq_msk_q;
  logic [1:0]       grant_s_q;
  logic [1:0]       initev_s_q;
  logic             initev_d1_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  scps_resp_state_t rst_q;

  wire wr      = PSEL && PENABLE && PWRITE;
  wire rd      = PSEL && PENABLE && !PWRITE;
  wire grant   = grant_s_q[1];
  wire init_ev = initev_s_q[1] && !initev_d1_q;
  wire sel     = ctrl_q[`SCPS_CTRL_SEL];
  wire arb_en  = ctrl_q[`SCPS_CTRL_ARB_EN];
  wire pkg_rdy = ctrl_q[`SCPS_CTRL_PKG_RDY];
  wire ch_rdy  = ctrl_q[`SCPS_CTRL_CH_RDY];

  // Transmit permission is common to all packets of the package.
  wire tx_allowed = sel && (!arb_en || grant);

  // Command decode.
  wire        cmd_wr   = wr && (PADDR == `SCPS_OFF_CMD);
  wire [7:0]  cmd_tag  = PWDATA[31:24];
  wire [6:0]  cmd_type = PWDATA[22:16];
  wire [2:0]  cmd_pkg  = PWDATA[7:5];
  wire [4:0]  cmd_ch   = PWDATA[4:0];
  wire        to_pkg   = (cmd_pkg == `SCPS_PKG_ID_DEF) && (cmd_ch == `SCPS_PKG_CH_ID);
  wire        to_ch    = (cmd_pkg == `SCPS_PKG_ID_DEF) && (cmd_ch == `SCPS_INT_CH_DEF);
  wire        pkg_ok   = to_pkg && pkg_rdy;
  wire        ch_ok    = to_ch && ch_rdy;
  wire        accept   = (pkg_ok || ch_ok) && !resp_v_q;
  wire        is_clr   = cmd_type == `SCPS_TYPE_CLR_INIT;
  wire        vendor   = cmd_type == `SCPS_TYPE_VENDOR;
  wire        init_blk = ch_ok && init_q && !is_clr && !vendor;
  wire        pop      = rd && (PADDR == `SCPS_OFF_RESP) && resp_v_q;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      grant_s_q   <= 2'b00;
      initev_s_q  <= 2'b00;
      initev_d1_q <= 1'b0;
    end else begin
      grant_s_q   <= {grant_s_q[0], ARB_GRANT};
      initev_s_q  <= {initev_s_q[0], INIT_EVENT};
      initev_d1_q <= initev_s_q[1];
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= `SCPS_CTRL_RST;
    end else if (wr && PADDR == `SCPS_OFF_CTRL) begin
      ctrl_q <= {27'h000_0000, PWDATA[4:0]};
    end
  end

  // Channel configuration state; reset enters the initial state.
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      init_q  <= 1'b1;
      ch_en_q <= 1'b0;
    end else if (init_ev) begin
      init_q  <= 1'b1;
      ch_en_q <= 1'b0;
    end else if (cmd_wr && accept && ch_ok) begin
      if (is_clr) begin
        init_q <= 1'b0;
      end else if (!init_q && cmd_type == `SCPS_TYPE_ENABLE) begin
        ch_en_q <= 1'b1;
      end else if (!init_q && cmd_type == `SCPS_TYPE_DISABLE) begin
        ch_en_q <= 1'b0;
      end
    end
  end

  // Single response slot: one per accepted command, tag echoed.
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      resp_v_q    <= 1'b0;
      resp_tag_q  <= 8'h00;
      resp_code_q <= 8'h00;
      resp_rsn_q  <= 8'h00;
    end else if (cmd_wr && accept) begin
      resp_v_q    <= 1'b1;
      resp_tag_q  <= cmd_tag;
      resp_code_q <= init_blk ? `SCPS_CODE_FAIL : `SCPS_CODE_OK;
      resp_rsn_q  <= init_blk ? `SCPS_REASON_INIT : `SCPS_REASON_NONE;
    end else if (pop) begin
      resp_v_q <= 1'b0;
    end
  end

  // Response send sequencing: held until transmit permission arrives.
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_q <= SCPS_IDLE;
    end else begin
      case (rst_q)
        SCPS_IDLE: if (resp_v_q) rst_q <= SCPS_HOLD;
        SCPS_HOLD: if (tx_allowed) rst_q <= SCPS_SEND;
        SCPS_SEND: if (!resp_v_q) rst_q <= SCPS_IDLE;
        default:   rst_q <= SCPS_IDLE;
      endcase
    end
  end

  // Gating outputs are registered so they never glitch on the pins.
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_BUF_EN   <= 1'b0;
      TX_RESP_OK  <= 1'b0;
      TX_UNREQ_OK <= 1'b0;
    end else begin
      TX_BUF_EN   <= tx_allowed;
      TX_RESP_OK  <= tx_allowed;
      TX_UNREQ_OK <= tx_allowed && ch_rdy && ch_en_q && !init_q;
    end
  end

  // Sticky status: a set in the same cycle as a clear wins.
  wire [2:0] irq_set = {cmd_wr && !accept, init_ev, cmd_wr && accept};
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_st_q  <= 3'h0;
      irq_msk_q <= 3'h0;
    end else begin
      if (wr && PADDR == `SCPS_OFF_IRQ_MSK) begin
        irq_msk_q <= PWDATA[2:0];
      end
      if (wr && PADDR == `SCPS_OFF_IRQ_ST) begin
        irq_st_q <= (irq_st_q & ~PWDATA[2:0]) | irq_set;
      end else begin
        irq_st_q <= irq_st_q | irq_set;
      end
    end
  end
  assign IRQ = |(irq_st_q & irq_msk_q);

  // Zero-wait APB: read data is registered in the setup cycle.
  wire known = (PADDR == `SCPS_OFF_CTRL) || (PADDR == `SCPS_OFF_CMD) ||
               (PADDR == `SCPS_OFF_RESP) || (PADDR == `SCPS_OFF_STAT) ||
               (PADDR == `SCPS_OFF_IRQ_ST) || (PADDR == `SCPS_OFF_IRQ_MSK);
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      pslverr_q <= !known;
      case (PADDR)
        `SCPS_OFF_CTRL:    prdata_q <= ctrl_q;
        `SCPS_OFF_RESP:    prdata_q <= {resp_v_q, 7'h00, resp_tag_q, resp_code_q, resp_rsn_q};
        `SCPS_OFF_STAT:    prdata_q <= {27'h000_0000, init_q, ch_en_q, tx_allowed, ch_rdy,
                                        pkg_rdy};
        `SCPS_OFF_IRQ_ST:  prdata_q <= {29'h0000_0000, irq_st_q};
        `SCPS_OFF_IRQ_MSK: prdata_q <= {29'h0000_0000, irq_msk_q};
        default:           prdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign PRDATA  = prdata_q;
  assign PREADY  = 1'b1;
  assign PSLVERR = pslverr_q && PSEL && PENABLE;

  a_deselect_silent: assert property (@(posedge MCLK) disable iff (!ARST_N)
    !$past(sel) |-> !TX_BUF_EN) else $error("buffers on while deselected");
  a_arb_needs_grant: assert property (@(posedge MCLK) disable iff (!ARST_N)
    $past(arb_en) && !$past(grant) |-> !TX_BUF_EN) else $error("sent without grant");
  a_arb_off_free: assert property (@(posedge MCLK) disable iff (!ARST_N)
    $past(sel) && !$past(arb_en) |-> TX_BUF_EN) else $error("selected but silent");
  a_sel_transmit: assert property (@(posedge MCLK) disable iff (!ARST_N)
    $past(tx_allowed) |-> TX_BUF_EN) else $error("allowed but buffers off");
  a_resp_tag_echo: assert property (@(posedge MCLK) disable iff (!ARST_N)
    cmd_wr && accept |=> resp_v_q && resp_tag_q == $past(cmd_tag)) else $error("tag lost");
  a_one_resp: assert property (@(posedge MCLK) disable iff (!ARST_N)
    cmd_wr && accept |=> resp_v_q) else $error("no response");
  a_pkg_not_ready: assert property (@(posedge MCLK) disable iff (!ARST_N)
    cmd_wr && to_pkg && !pkg_rdy && !resp_v_q |=> !resp_v_q) else $error("pkg took cmd");
  a_ch_not_ready: assert property (@(posedge MCLK) disable iff (!ARST_N)
    cmd_wr && to_ch && !ch_rdy && !resp_v_q |=> !resp_v_q) else $error("ch took cmd");
  a_init_fail: assert property (@(posedge MCLK) disable iff (!ARST_N)
    cmd_wr && accept && init_blk |=> resp_code_q == `SCPS_CODE_FAIL
    && resp_rsn_q == `SCPS_REASON_INIT) else $error("init not flagged");
  a_init_disables: assert property (@(posedge MCLK) disable iff (!ARST_N)
    init_ev |=> init_q && !ch_en_q ##1 !TX_UNREQ_OK) else $error("init left enabled");
  a_unreq_gate: assert property (@(posedge MCLK) disable iff (!ARST_N)
    !$past(ch_en_q) |-> !TX_UNREQ_OK) else $error("disabled channel sends");
  c_resp_sent: cover property (@(posedge MCLK) disable iff (!ARST_N)
    rst_q == SCPS_HOLD ##[1:20] rst_q == SCPS_SEND);
  c_clear_init: cover property (@(posedge MCLK) disable iff (!ARST_N) init_q ##1 !init_q);
  c_unreq_on: cover property (@(posedge MCLK) disable iff (!ARST_N) TX_UNREQ_OK);
endmodule

// ===== verification/scps_mc_model.sv
// Management controller model: issues APB transfers into the state block.
// Assumes the caller starts each transfer from procedural code on clk.
`timescale 1ns/1ps
module scps_mc_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // A released bus must not keep showing the old values.
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ===== verification/tb_sideband_package_channel_state.sv
// Self-checking bench for the sideband package and channel state block.
// Assumes the map header and the APB management controller model.
`timescale 1ns/1ps
`include "scps_map.svh"
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("FAIL %0t %s", $time, m); end end
module tb_sideband_package_channel_state;
  logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr, err_q;
  logic        arb_grant, init_event, tx_buf_en, tx_resp_ok, tx_unreq_ok, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [7:0]  tag, tag0;
  logic [2:0]  v;
  int          mismatches, checked;
  scps_core scps_core_inst (.MCLK(mclk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .ARB_GRANT(arb_grant), .INIT_EVENT(init_event),
    .TX_BUF_EN(tx_buf_en), .TX_RESP_OK(tx_resp_ok), .TX_UNREQ_OK(tx_unreq_ok), .IRQ(irq));
  scps_mc_model scps_mc_model_inst (.clk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  function automatic logic [31:0] resp_w(logic [7:0] t, logic [7:0] c, logic [7:0] r);
    return {1'b1, 7'h00, t, c, r};
  endfunction
  function automatic logic gate(logic s, logic a, logic g);
    return s & (~a | g);
  endfunction
  task automatic wr(logic [11:0] a, logic [31:0] d);
    scps_mc_model_inst.xfer(1'b1, a, d, rd_q, err_q);
  endtask
  task automatic rd(logic [11:0] a);
    scps_mc_model_inst.xfer(1'b0, a, 32'h0000_0000, rd_q, err_q);
  endtask
  // Gating outputs lag the pin grant by three cycles, so four covers both paths.
  task automatic ctrl(logic s, logic a, logic p, logic c);
    wr(`SCPS_OFF_CTRL, {28'h000_0000, c, p, a, s});
    repeat (4) @(posedge mclk);
  endtask
  task automatic cmd(logic [6:0] t, logic [4:0] c);
    tag = tag + 8'h01 + 8'($urandom % 200);
    wr(`SCPS_OFF_CMD, {tag, 1'b0, t, 8'h00, `SCPS_PKG_ID_DEF, c});
  endtask
  task automatic resp(logic [7:0] t, logic [7:0] c, logic [7:0] r);
    rd(`SCPS_OFF_RESP);
    `CHK(rd_q, resp_w(t, c, r), "response");
    rd(`SCPS_OFF_RESP);
    `CHK(rd_q[31], 1'b0, "extra response");
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always #12.5 mclk = ~mclk;
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    wrap_up;
  end
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    arb_grant = 1'b0;
    init_event = 1'b0;
    tag = 8'h00;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    void'($urandom(84));
    rd(`SCPS_OFF_CTRL);
    `CHK(rd_q, `SCPS_CTRL_RST, "ctrl reset");
    rd(`SCPS_OFF_STAT);
    `CHK(rd_q, 32'h0000_0011, "stat reset");
    `CHK(tx_buf_en, 1'b0, "buffers on");
    rd(12'h0FC);
    `CHK({err_q, rd_q}, 33'h1_0000_0000, "unmapped");
    wr(`SCPS_OFF_IRQ_MSK, 32'h0000_0007);
    cmd(`SCPS_TYPE_ENABLE, `SCPS_INT_CH_DEF);
    rd(`SCPS_OFF_IRQ_ST);
    `CHK({rd_q[2], rd_q[0], irq}, 3'b101, "refusal");
    wr(`SCPS_OFF_IRQ_ST, 32'h0000_0007);
    rd(`SCPS_OFF_RESP);
    `CHK({rd_q[31], irq}, 2'b00, "irq clear");
    ctrl(1'b1, 1'b0, 1'b0, 1'b1);
    cmd(`SCPS_TYPE_VENDOR, `SCPS_PKG_CH_ID);
    rd(`SCPS_OFF_RESP);
    `CHK(rd_q[31], 1'b0, "pkg not ready");
    ctrl(1'b1, 1'b0, 1'b1, 1'b1);
    cmd(`SCPS_TYPE_VENDOR, `SCPS_PKG_CH_ID);
    rd(`SCPS_OFF_RESP);
    `CHK(rd_q[31:16], {1'b1, 7'h00, tag}, "pkg answer");
    cmd(`SCPS_TYPE_VENDOR, `SCPS_INT_CH_DEF);
    resp(tag, `SCPS_CODE_OK, `SCPS_REASON_NONE);
    cmd(`SCPS_TYPE_DISABLE, `SCPS_INT_CH_DEF);
    tag0 = tag;
    cmd(`SCPS_TYPE_ENABLE, `SCPS_INT_CH_DEF);
    resp(tag0, `SCPS_CODE_FAIL, `SCPS_REASON_INIT);
    cmd(`SCPS_TYPE_CLR_INIT, `SCPS_INT_CH_DEF);
    resp(tag, `SCPS_CODE_OK, `SCPS_REASON_NONE);
    cmd(`SCPS_TYPE_ENABLE, `SCPS_INT_CH_DEF);
    resp(tag, `SCPS_CODE_OK, `SCPS_REASON_NONE);
    for (int i = 0; i < 16; i++) begin
      v = (i < 8) ? i[2:0] : 3'($urandom);
      arb_grant <= v[2];
      ctrl(v[0], v[1], 1'b1, 1'b1);
      `CHK({tx_buf_en, tx_resp_ok}, {2{gate(v[0], v[1], v[2])}}, "tx gate");
      `CHK(tx_unreq_ok, gate(v[0], v[1], v[2]), "unreq gate");
    end
    ctrl(1'b1, 1'b0, 1'b1, 1'b1);
    cmd(`SCPS_TYPE_DISABLE, `SCPS_INT_CH_DEF);
    resp(tag, `SCPS_CODE_OK, `SCPS_REASON_NONE);
    `CHK({tx_resp_ok, tx_unreq_ok}, 2'b10, "disabled");
    wr(`SCPS_OFF_IRQ_ST, 32'h0000_0007);
    wr(`SCPS_OFF_IRQ_MSK, 32'h0000_0000);
    cmd(`SCPS_TYPE_ENABLE, `SCPS_INT_CH_DEF);
    `CHK(irq, 1'b0, "masked irq");
    resp(tag, `SCPS_CODE_OK, `SCPS_REASON_NONE);
    init_event <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHK(tx_unreq_ok, 1'b0, "init unreq");
    rd(`SCPS_OFF_STAT);
    `CHK(rd_q[4:3], 2'b10, "init disables");
    rd(`SCPS_OFF_IRQ_ST);
    `CHK(rd_q[1], 1'b1, "init flag");
    init_event <= 1'b0;
    wrap_up;
  end
endmodule
